// ==== hdl/iox_expander.sv ====
`timescale 1ns/10ps
`include "iox_params.svh"

// Overview of operation
// - two ports: direction, input, output, polarity bytes
// - pins start as inputs; direction writable
// - input read inverted by polarity; all readable
// - reset pin equals power-on initialisation
// - registers held default while reset pin low
// - power-on reset holds until supply good
// - interrupt when input pin differs from captured
// - both edges raise interrupt within bounded delay
// - interrupt clears on revert or port read
// - read clear at acknowledge before data byte
// - change during clearing acknowledge may vanish
// - every later change signalled again
// - foreign traffic, output pins never interrupt
// - output-to-input switch may raise interrupt
// - clearing tracked separately per port
// - input pin: both drivers off
// - output pin: one driver from output bit
// - address 11101, two straps, read/write bit
// - command low bits select register, defaults
// - register pointer persists across reads
// - output reads give flip-flop, not pin
module iox_expander (
  // clocks and resets
  input  wire logic              mclk_i,
  input  wire logic              scl_clk_i,
  input  wire logic              reset_i,
  input  wire logic              reset_pin_n_i,
  // address straps
  input  wire logic              addr_strap_lo_i,
  input  wire logic              addr_strap_hi_i,
  // serial data line
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // port pins
  input  wire iox_pkg::iox_byte_t port0_pins_i,
  output iox_pkg::iox_byte_t     port0_pins_o,
  output iox_pkg::iox_byte_t     port0_pins_oe_o,
  input  wire iox_pkg::iox_byte_t port1_pins_i,
  output iox_pkg::iox_byte_t     port1_pins_o,
  output iox_pkg::iox_byte_t     port1_pins_oe_o,
  // interrupt, open drain
  output logic                   irq_n_o,
  output logic                   irq_oe_o
);
  import iox_pkg::*;

  localparam int IRQ_DLY_CYC = `IOX_IRQ_VALID_DELAY_NS / `IOX_MCLK_PERIOD_NS;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [7:0] iox_sel(input logic [15:0] v, input logic hi);
    iox_sel = hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [7:0] iox_reg_rd(input logic [2:0]  p,
                                            input logic [15:0] pin_v,
                                            input logic [15:0] out_v,
                                            input logic [15:0] pol_v,
                                            input logic [15:0] dir_v);
    case (p[2:1])
      `IOX_KIND_INPUT:    iox_reg_rd = iox_sel(pin_v ^ pol_v, p[0]);
      `IOX_KIND_OUTPUT:   iox_reg_rd = iox_sel(out_v, p[0]);
      `IOX_KIND_POLARITY: iox_reg_rd = iox_sel(pol_v, p[0]);
      default:            iox_reg_rd = iox_sel(dir_v, p[0]);
    endcase
  endfunction

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  iox_link_if lnk ();

  iox_link_rx u_link (
    .scl_clk_i (scl_clk_i),
    .sda_i     (sda_i),
    .lnk       (lnk.rx)
  );

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`IOX_SYN_W-1:0] raw;
  logic [`IOX_SYN_W-1:0] s1_q;
  logic [`IOX_SYN_W-1:0] s2_q;
  logic [`IOX_SYN_W-1:0] s3_q;
  logic [`IOX_SYN_W-1:0] stab_q;
  logic [`IOX_SYN_W-1:0] stab_d;
  logic [2:0]            tg_q;

  assign raw = {addr_strap_hi_i, addr_strap_lo_i, reset_pin_n_i, sda_i, scl_clk_i,
                port1_pins_i, port0_pins_i};

  always_comb begin
    // a level counts once stages two and three agree
    stab_d = (s3_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge mclk_i) begin
    s1_q   <= raw;
    s2_q   <= s1_q;
    s3_q   <= s2_q;
    stab_q <= stab_d;
    tg_q   <= {tg_q[1:0], lnk.bit_tgl};
  end

  // ----------------------------------------
  // core state
  // ----------------------------------------
  iox_state_t  state_q;
  iox_state_t  state_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [7:0]  shr_q;
  logic [7:0]  shr_d;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic        rw_q;
  logic        rw_d;
  logic [2:0]  ptr_q;
  logic [2:0]  ptr_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic [15:0] pol_q;
  logic [15:0] pol_d;
  logic [15:0] dir_q;
  logic [15:0] dir_d;
  logic [15:0] in_q;
  logic [15:0] in_d;
  logic [15:0] pin_oe_q;
  logic [15:0] pin_oe_d;
  logic        sda_oe_q;
  logic        sda_oe_d;
  logic        irq_oe_q;
  logic        irq_oe_d;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic        rst_all_q;

  logic        rst_all;
  logic [15:0] pins;
  logic        scl;
  logic        sda;
  logic        bit_ev;
  logic        bit_val;
  logic        start;
  logic        stop;
  logic        scl_fall;
  logic        addr_hit;
  logic        load_rd;
  logic [2:0]  rd_ptr;
  logic [7:0]  wr_byte;

  assign rst_all  = reset_i | ~stab_q[`IOX_SYN_RSTN];
  assign pins     = stab_q[15:0];
  assign scl      = stab_q[`IOX_SYN_SCL];
  assign sda      = stab_q[`IOX_SYN_SDA];
  assign bit_ev   = tg_q[1] ^ tg_q[2];
  assign bit_val  = lnk.bit_val;
  assign start    = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop     = scl & scl_prev_q & ~sda_prev_q & sda;
  assign scl_fall = scl_prev_q & ~scl;
  assign wr_byte  = {shr_q[6:0], bit_val};
  assign addr_hit = shr_q[6:0] == {`IOX_ADDR_FIXED, stab_q[`IOX_SYN_STRAP_HI],
                                   stab_q[`IOX_SYN_STRAP_LO]};
  assign lnk.rst_req = rst_all_q;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    shr_d    = shr_q;
    tx_d     = tx_q;
    rw_d     = rw_q;
    ptr_d    = ptr_q;
    out_d    = out_q;
    pol_d    = pol_q;
    dir_d    = dir_q;
    in_d     = in_q;
    sda_oe_d = sda_oe_q;
    load_rd  = 1'b0;
    rd_ptr   = ptr_q;
    if (rst_all) begin
      // held at defaults for as long as either reset stands
      state_d  = IOX_IDLE;
      cnt_d    = 4'h0;
      shr_d    = 8'h00;
      tx_d     = 8'h00;
      rw_d     = 1'b0;
      ptr_d    = `IOX_PTR_RST;
      out_d    = {2{`IOX_OUT_RST}};
      pol_d    = {2{`IOX_POL_RST}};
      dir_d    = {2{`IOX_DIR_RST}};
      in_d     = pins;
      sda_oe_d = 1'b0;
    end else if (stop) begin
      state_d  = IOX_IDLE;
      sda_oe_d = 1'b0;
    end else if (start) begin
      state_d  = IOX_ADDR;
      cnt_d    = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      if (bit_ev) begin
        shr_d = wr_byte;
        cnt_d = cnt_q + 4'h1;
        case (state_q)
          IOX_ADDR: begin
            if (cnt_q == 4'h7) begin
              // other targets' traffic leaves everything alone
              state_d = addr_hit ? IOX_ACKA : IOX_IDLE;
              rw_d    = bit_val;
            end
          end
          IOX_ACKA: begin
            cnt_d   = 4'h0;
            load_rd = rw_q;
            state_d = rw_q ? IOX_RDAT : IOX_CMD;
          end
          IOX_CMD: begin
            if (cnt_q == 4'h7) begin
              ptr_d   = wr_byte[2:0];
              state_d = IOX_ACKC;
            end
          end
          IOX_ACKC: begin
            cnt_d   = 4'h0;
            state_d = IOX_WDAT;
          end
          IOX_WDAT: begin
            if (cnt_q == 4'h7) begin
              case (ptr_q[2:1])
                `IOX_KIND_OUTPUT:    out_d[{ptr_q[0], 3'h0} +: 8] = wr_byte;
                `IOX_KIND_POLARITY:  pol_d[{ptr_q[0], 3'h0} +: 8] = wr_byte;
                `IOX_KIND_DIRECTION: dir_d[{ptr_q[0], 3'h0} +: 8] = wr_byte;
                default: ;
              endcase
              ptr_d[0] = ~ptr_q[0];
              state_d  = IOX_ACKW;
            end
          end
          IOX_ACKW: begin
            cnt_d   = 4'h0;
            state_d = IOX_WDAT;
          end
          IOX_RDAT: begin
            tx_d = {tx_q[6:0], 1'b0};
            if (cnt_q == 4'h7) begin
              state_d = IOX_RACK;
            end
          end
          IOX_RACK: begin
            cnt_d = 4'h0;
            if (!bit_val) begin
              // acknowledged: next byte of the same pair
              ptr_d[0] = ~ptr_q[0];
              rd_ptr   = {ptr_q[2:1], ~ptr_q[0]};
              load_rd  = 1'b1;
              state_d  = IOX_RDAT;
            end else begin
              state_d = IOX_IDLE;
            end
          end
          default: ;
        endcase
      end
      if (load_rd) begin
        tx_d = iox_reg_rd(rd_ptr, pins, out_q, pol_q, dir_q);
        // a change landing in this very cycle may be absorbed
        if (rd_ptr[2:1] == `IOX_KIND_INPUT) begin
          in_d[{rd_ptr[0], 3'h0} +: 8] = iox_sel(pins, rd_ptr[0]);
        end
      end
      if (scl_fall) begin
        case (state_q)
          IOX_ACKA, IOX_ACKC, IOX_ACKW: sda_oe_d = 1'b1;
          IOX_RDAT:                     sda_oe_d = ~tx_q[7];
          default:                      sda_oe_d = 1'b0;
        endcase
      end
    end
  end

  always_comb begin
    pin_oe_d = ~dir_d;
    // only input-mode pins that differ from the captured value count
    irq_oe_d = ~rst_all & (|((pins ^ in_q) & dir_q));
  end

  always_ff @(posedge mclk_i) begin
    state_q    <= state_d;
    cnt_q      <= cnt_d;
    shr_q      <= shr_d;
    tx_q       <= tx_d;
    rw_q       <= rw_d;
    ptr_q      <= ptr_d;
    out_q      <= out_d;
    pol_q      <= pol_d;
    dir_q      <= dir_d;
    in_q       <= in_d;
    pin_oe_q   <= pin_oe_d;
    sda_oe_q   <= sda_oe_d;
    irq_oe_q   <= irq_oe_d;
    scl_prev_q <= scl;
    sda_prev_q <= sda;
    rst_all_q  <= rst_all;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    sda_o   <= 1'b0;
    irq_n_o <= 1'b0;
  end

  assign sda_oe_o        = sda_oe_q;
  assign irq_oe_o        = irq_oe_q;
  assign port0_pins_o    = out_q[7:0];
  assign port1_pins_o    = out_q[15:8];
  assign port0_pins_oe_o = pin_oe_q[7:0];
  assign port1_pins_oe_o = pin_oe_q[15:8];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [15:0] raw_diff;
  assign raw_diff = ({port1_pins_i, port0_pins_i} ^ in_q) & dir_q;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_pin_reset_defaults: assert property (rst_all |=> (dir_q == {2{`IOX_DIR_RST}}) &&
      (out_q == {2{`IOX_OUT_RST}}) && (pol_q == {2{`IOX_POL_RST}}) && (state_q == IOX_IDLE) && !sda_oe_o)
    else $error("registers not at defaults after reset pin");

  a_irq_on_change: assert property ((raw_diff != 16'h0 && $stable(raw_diff) && !load_rd && !rst_all)[*5]
      |-> ##[0:IRQ_DLY_CYC] irq_oe_o)
    else $error("interrupt not raised for differing input pin");

  a_irq_released: assert property ((raw_diff == 16'h0 && !rst_all)[*6] |-> !irq_oe_o)
    else $error("interrupt pending without differing input pin");

  a_read_clears_port: assert property ((load_rd && rd_ptr == 3'h0)
      |=> (in_q[7:0] == $past(pins[7:0])) && $stable(in_q[15:8]))
    else $error("port read captured the wrong port");

  a_input_hiz: assert property (((port0_pins_oe_o & dir_q[7:0]) == 8'h00) &&
      ((port1_pins_oe_o & dir_q[15:8]) == 8'h00))
    else $error("input pin is driven");

  a_output_write: assert property ((bit_ev && state_q == IOX_WDAT && cnt_q == 4'h7 && ptr_q == 3'h2
      && !rst_all && !start && !stop) |=> ##1 (port0_pins_o == $past(wr_byte, 2)))
    else $error("output write not reflected on pins");

  a_addr_foreign: assert property ((bit_ev && state_q == IOX_ADDR && cnt_q == 4'h7 && !addr_hit
      && !rst_all && !start && !stop) |=> state_q == IOX_IDLE)
    else $error("foreign address accepted");

  a_ptr_persists: assert property ((!(bit_ev && state_q == IOX_CMD) && !rst_all)
      |=> $stable(ptr_q[2:1]))
    else $error("register pair changed without command byte");

  a_input_read_data: assert property ((load_rd && rd_ptr == 3'h0)
      |=> tx_q == $past(pins[7:0] ^ pol_q[7:0]))
    else $error("input read not polarity adjusted");

  a_ack_drive: assert property ((state_q == IOX_ACKA && scl_fall && !start && !stop && !rst_all)
      |=> sda_oe_o)
    else $error("address acknowledge not driven");
endmodule

// ==== hdl/iox_link_if.sv ====
`timescale 1ns/10ps

interface iox_link_if;
  logic rst_req;
  logic bit_tgl;
  logic bit_val;

  modport rx (
    input  rst_req,
    output bit_tgl,
    output bit_val
  );

  modport core (
    output rst_req,
    input  bit_tgl,
    input  bit_val
  );
endinterface

// ==== hdl/iox_link_rx.sv ====
`timescale 1ns/10ps

// samples sda on each scl rise; toggle marks a new bit for the core
module iox_link_rx (
  // link clock and data
  input  wire logic scl_clk_i,
  input  wire logic sda_i,
  // towards the core
  iox_link_if.rx    lnk
);
  logic tgl_q;
  logic tgl_d;
  logic val_q;
  logic val_d;

  always_comb begin
    tgl_d = ~tgl_q;
    val_d = sda_i;
  end

  // scl is parked high outside frames, so reset must act without its edges
  // and must not swallow the first bits after release
  always_ff @(posedge scl_clk_i or posedge lnk.rst_req) begin
    if (lnk.rst_req) begin
      tgl_q <= 1'b0;
      val_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
      val_q <= val_d;
    end
  end

  // value stays put for a whole scl period, so the core reads it after the toggle
  assign lnk.bit_tgl = tgl_q;
  assign lnk.bit_val = val_q;
endmodule

// ==== hdl/iox_params.svh ====
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH

// ----------------------------------------
// target address and register map
// ----------------------------------------
`define IOX_ADDR_FIXED          5'h1D
`define IOX_KIND_INPUT          2'h0
`define IOX_KIND_OUTPUT         2'h1
`define IOX_KIND_POLARITY       2'h2
`define IOX_KIND_DIRECTION      2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOX_OUT_RST             8'hFF
`define IOX_POL_RST             8'h00
`define IOX_DIR_RST             8'hFF
`define IOX_PTR_RST             3'h0

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define IOX_SYN_W               21
`define IOX_SYN_SCL             16
`define IOX_SYN_SDA             17
`define IOX_SYN_RSTN            18
`define IOX_SYN_STRAP_LO        19
`define IOX_SYN_STRAP_HI        20

// ----------------------------------------
// timing
// ----------------------------------------
`define IOX_MCLK_PERIOD_NS      50
`define IOX_IRQ_VALID_DELAY_NS  4000

`endif

// ==== hdl/iox_pkg.sv ====
package iox_pkg;

  typedef logic [7:0] iox_byte_t;

  typedef enum logic [3:0] {
    IOX_IDLE = 4'h0,
    IOX_ADDR = 4'h1,
    IOX_ACKA = 4'h2,
    IOX_CMD  = 4'h3,
    IOX_ACKC = 4'h4,
    IOX_WDAT = 4'h5,
    IOX_ACKW = 4'h6,
    IOX_RDAT = 4'h7,
    IOX_RACK = 4'h8
  } iox_state_t;

endpackage

// ==== test/iox_ctrl_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------
// bus controller, open-drain sda
// ----------------------------------------
module iox_ctrl_model (
  // link tick and lines
  input  wire logic lk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  import iox_pkg::*;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // set both lines after a tick, hold five ticks
  task automatic sv(input logic c, input logic d);
    @(posedge lk_i);
    scl_o <= c;
    sda_low_o <= d;
    repeat (5) @(posedge lk_i);
  endtask

  // scl falls before sda moves, never together
  task automatic start;
    sv(1'b0, sda_low_o);
    sv(1'b0, 1'b0);
    sv(1'b1, 1'b0);
    sv(1'b1, 1'b1);
  endtask

  task automatic stop;
    sv(1'b0, sda_low_o);
    sv(1'b0, 1'b1);
    sv(1'b1, 1'b1);
    sv(1'b1, 1'b0);
  endtask

  task automatic bit_io(input logic b, output logic s);
    sv(1'b0, sda_low_o);
    sv(1'b0, ~b);
    sv(1'b1, ~b);
    s = sda_i;
  endtask

  // one byte then the acknowledge bit
  task automatic xfer(input iox_byte_t tx, input logic a9, output iox_byte_t rx, output logic s9);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(a9, s9);
  endtask
endmodule

// ==== test/test_i2c_16bit_io_expander.sv ====
`timescale 1ns/10ps

module test_i2c_16bit_io_expander;
  import iox_pkg::*;
  localparam int CYC_MAX = 80000;
  logic           mclk        = 1'b0;
  logic           lk          = 1'b0;
  logic           reset       = 1'b1;
  logic           rst_pin_n   = 1'b1;
  logic [1:0]     strap       = 2'h1;
  logic [1:0]     tgt         = 2'h1;
  iox_byte_t      ext0        = 8'h0C;
  iox_byte_t      ext1        = 8'h33;
  iox_byte_t      po0, po1, oe0, oe1;
  logic           scl, sda_low, sda_o, sda_oe, irq_oe, irq_n;
  wire            sda         = ~(sda_low | (sda_oe & ~sda_o));
  wire iox_byte_t pin0        = (oe0 & po0) | (~oe0 & ext0);
  wire iox_byte_t pin1        = (oe1 & po1) | (~oe1 & ext1);
  int             n_mismatch  = 0;
  int             checks_done = 0;
  int             cyc         = 0;
  iox_byte_t      dflt [6]    = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};

  initial begin
    forever #25 mclk = ~mclk;
  end
  initial begin
    #13;
    forever #62.5 lk = ~lk;
  end

  iox_expander i_iox_expander (
    .mclk_i(mclk), .scl_clk_i(scl), .reset_i(reset), .reset_pin_n_i(rst_pin_n),
    .addr_strap_lo_i(strap[0]), .addr_strap_hi_i(strap[1]),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .port0_pins_i(pin0), .port0_pins_o(po0), .port0_pins_oe_o(oe0),
    .port1_pins_i(pin1), .port1_pins_o(po1), .port1_pins_oe_o(oe1),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe)
  );

  iox_ctrl_model i_iox_ctrl_model (.lk_i(lk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic iox_byte_t adr(input logic r);
    return {5'h1D, tgt, r};
  endfunction

  task automatic wr(input iox_byte_t c, input iox_byte_t d, input logic ok);
    iox_byte_t rx;
    logic      s;
    i_iox_ctrl_model.start;
    i_iox_ctrl_model.xfer(adr(1'b0), 1'b1, rx, s);
    chk("write addr ack", {7'h0, ~ok}, {7'h0, s});
    if (ok) begin
      i_iox_ctrl_model.xfer(c, 1'b1, rx, s);
      chk("cmd ack", 8'h00, {7'h0, s});
      i_iox_ctrl_model.xfer(d, 1'b1, rx, s);
      chk("data ack", 8'h00, {7'h0, s});
    end
    i_iox_ctrl_model.stop;
  endtask

  task automatic rd(input iox_byte_t c, input logic new_ptr, input iox_byte_t e);
    iox_byte_t rx;
    logic      s;
    if (new_ptr) begin
      i_iox_ctrl_model.start;
      i_iox_ctrl_model.xfer(adr(1'b0), 1'b1, rx, s);
      i_iox_ctrl_model.xfer(c, 1'b1, rx, s);
    end
    i_iox_ctrl_model.start;
    i_iox_ctrl_model.xfer(adr(1'b1), 1'b1, rx, s);
    chk("read addr ack", 8'h00, {7'h0, s});
    i_iox_ctrl_model.xfer(8'hFF, 1'b1, rx, s);
    chk($sformatf("register %0h", c), e, rx);
    i_iox_ctrl_model.stop;
  endtask

  // wait a bounded time for the interrupt line state
  task automatic irq_is(input logic e, input int n);
    for (int i = 0; i < n && irq_oe !== e; i++) @(negedge mclk);
    chk("irq_oe_o", {7'h0, e}, {7'h0, irq_oe});
    chk("irq line", {7'h0, ~e}, {7'h0, ~(irq_oe & ~irq_n)});
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      n_mismatch++;
      finish_test;
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (6) @(negedge mclk);
    chk("pins oe 0", 8'h00, oe0);
    chk("pins oe 1", 8'h00, oe1);
    chk("pins out 1", 8'hFF, po1);
    foreach (dflt[i]) rd(8'(i + 2), 1'b1, dflt[i]);
    rd(8'h00, 1'b1, 8'h0C);
    $display("test defaults done");
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      strap = 2'(k);
      tgt = 2'(k);
      repeat (6) @(negedge mclk);
      rd(8'h07, 1'b1, 8'hFF);
    end
    @(negedge mclk);
    strap = 2'h1;
    tgt = 2'h1;
    repeat (6) @(negedge mclk);
    $display("test address done");
    wr(8'h02, 8'h5A, 1'b1);
    wr(8'h06, 8'h0F, 1'b1);
    chk("pins oe 0", 8'hF0, oe0);
    chk("pins out 0", 8'h5A, po0);
    rd(8'h02, 1'b1, 8'h5A);
    rd(8'h02, 1'b0, 8'h5A);
    wr(8'h00, 8'hAA, 1'b1);
    rd(8'h00, 1'b1, 8'h5C);
    wr(8'h05, 8'hF0, 1'b1);
    rd(8'h01, 1'b1, 8'hC3);
    $display("test registers done");
    irq_is(1'b0, 1);
    wr(8'h02, 8'h4A, 1'b1);
    repeat (100) @(negedge mclk);
    irq_is(1'b0, 1);
    ext0 = 8'h0D;
    irq_is(1'b1, 80);
    @(negedge mclk);
    ext0 = 8'h0C;
    irq_is(1'b0, 80);
    @(negedge mclk);
    ext0 = 8'h08;
    irq_is(1'b1, 80);
    tgt = 2'h2;
    wr(8'h02, 8'h00, 1'b0);
    tgt = 2'h1;
    irq_is(1'b1, 1);
    rd(8'h01, 1'b1, 8'hC3);
    irq_is(1'b1, 1);
    rd(8'h00, 1'b1, 8'h48);
    irq_is(1'b0, 1);
    @(negedge mclk);
    ext0 = 8'h0C;
    irq_is(1'b1, 80);
    rd(8'h00, 1'b1, 8'h4C);
    irq_is(1'b0, 1);
    @(negedge mclk);
    ext0 = 8'h8C;
    repeat (100) @(negedge mclk);
    irq_is(1'b0, 1);
    wr(8'h06, 8'h8F, 1'b1);
    irq_is(1'b1, 80);
    rd(8'h00, 1'b1, 8'hCC);
    irq_is(1'b0, 1);
    $display("test interrupt done");
    @(negedge mclk);
    ext0 = 8'h0D;
    irq_is(1'b1, 80);
    @(negedge mclk);
    rst_pin_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk("pins oe 0", 8'h00, oe0);
    chk("pins out 0", 8'hFF, po0);
    irq_is(1'b0, 1);
    wr(8'h02, 8'h00, 1'b0);
    chk("pins out 0", 8'hFF, po0);
    @(negedge mclk);
    rst_pin_n = 1'b1;
    repeat (8) @(negedge mclk);
    rd(8'h00, 1'b0, 8'h0D);
    rd(8'h06, 1'b1, 8'hFF);
    $display("test reset pin done");
    finish_test;
  end
endmodule
